// ### rtl/ema_addr_gen.sv
// module: AHB-Lite register slave and external structure address former
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module ema_addr_gen (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic req_valid, // address request
    input wire ema_pkg::ema_req_t req, // request fields
    output logic rsp_valid, // answer strobe
    output ema_pkg::ema_rsp_t rsp // formed address
);
    import ema_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_WDATA = 2'b10
    } ema_bus_t;

    ema_bus_t state, next_state;
    logic [29:0] wr_idx, next_wr_idx;
    logic [31:0] next_hrdata;
    logic [15:0] tx_cell_fifo_base, next_tx_cell_fifo_base;
    logic [15:0] rx_reassembly_ctrl_base, next_rx_reassembly_ctrl_base;
    logic [15:0] rx_cell_fifo_base, next_rx_cell_fifo_base;
    logic [15:0] ext_to_int_ctrl_base, next_ext_to_int_ctrl_base;
    logic [15:0] cfg, next_cfg;
    logic [15:0] status, next_status;
    logic addr_phase;
    logic [29:0] idx;

    assign addr_phase = hsel && hready && htrans[1];
    assign idx = haddr[31:2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // bus slave: zero wait states, unmapped reads zero, writes dropped
    always_comb begin
        next_state = state;
        next_wr_idx = wr_idx;
        next_hrdata = hrdata;
        if (addr_phase) begin
            next_state = hwrite ? S_WDATA : S_IDLE;
            next_wr_idx = idx;
            next_hrdata = 32'h0000_0000;
            if (!hwrite) begin
                unique case (idx)
                    IDX_TX_FIFO_BASE: next_hrdata = {16'h0000, tx_cell_fifo_base};
                    IDX_RSM_BASE: next_hrdata = {16'h0000, rx_reassembly_ctrl_base};
                    IDX_RX_FIFO_BASE: next_hrdata = {16'h0000, rx_cell_fifo_base};
                    IDX_EIM_BASE: next_hrdata = {16'h0000, ext_to_int_ctrl_base};
                    IDX_CFG: next_hrdata = {16'h0000, cfg};
                    IDX_STATUS: next_hrdata = {16'h0000, status};
                    default: next_hrdata = 32'h0000_0000;
                endcase
            end
        end else if (hready) begin
            next_state = S_IDLE;
        end
    end

    always_comb begin
        next_tx_cell_fifo_base = tx_cell_fifo_base;
        next_rx_reassembly_ctrl_base = rx_reassembly_ctrl_base;
        next_rx_cell_fifo_base = rx_cell_fifo_base;
        next_ext_to_int_ctrl_base = ext_to_int_ctrl_base;
        next_cfg = cfg;
        if (state == S_WDATA) begin
            unique case (wr_idx)
                IDX_TX_FIFO_BASE: next_tx_cell_fifo_base = hwdata[15:0];
                IDX_RSM_BASE: next_rx_reassembly_ctrl_base = hwdata[15:0];
                IDX_RX_FIFO_BASE: next_rx_cell_fifo_base = hwdata[15:0];
                IDX_EIM_BASE: next_ext_to_int_ctrl_base = hwdata[15:0];
                IDX_CFG: next_cfg = hwdata[15:0];
                default: next_cfg = cfg;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_IDLE;
            wr_idx <= 30'h0000_0000;
            hrdata <= 32'h0000_0000;
            tx_cell_fifo_base <= RST_BASE;
            rx_reassembly_ctrl_base <= RST_BASE;
            rx_cell_fifo_base <= RST_BASE;
            ext_to_int_ctrl_base <= RST_BASE;
            cfg <= RST_CFG;
        end else begin
            state <= next_state;
            wr_idx <= next_wr_idx;
            hrdata <= next_hrdata;
            tx_cell_fifo_base <= next_tx_cell_fifo_base;
            rx_reassembly_ctrl_base <= next_rx_reassembly_ctrl_base;
            rx_cell_fifo_base <= next_rx_cell_fifo_base;
            ext_to_int_ctrl_base <= next_ext_to_int_ctrl_base;
            cfg <= next_cfg;
        end
    end

    // address forming
    logic [20:0] win8k, win_rsm, win_cbuf;
    logic [20:0] eim_high, eim_low, eim_addr;
    logic [20:0] cb_high, cb_low, cb_addr;
    logic [20:0] rsm_high, rsm_low, rsm_addr;
    logic [20:0] txf_high, txf_low, txf_addr;
    logic [20:0] rxf_high, rxf_low, rxf_addr;
    logic [6:0] txf_cell, rxf_cell;
    logic txf_en, rxf_en;

    assign win8k = 21'((1 << WIN8K_W) - 1);
    assign win_rsm = 21'((1 << RSM_WIN_W) - 1);
    assign win_cbuf = (21'(1) << (CBUF_MIN_SHIFT + int'(req.eim_size))) - 21'(1);
    assign txf_en = cfg[CFG_TXF_EN_BIT];
    assign rxf_en = cfg[CFG_RXF_EN_BIT];
    // cell index wraps at fifo size 16 << code
    assign txf_cell = req.entry[6:0]
        & 7'((8'h10 << cfg[CFG_TXF_SIZE_LSB +: 2]) - 8'h01);
    assign rxf_cell = req.entry[6:0]
        & 7'((cfg[CFG_RXF_SIZE_LSB +: 2] == 2'd3 ? 7'h7f : cfg[CFG_RXF_SIZE_LSB +: 2] == 2'd2 ? 7'h3f
        : cfg[CFG_RXF_SIZE_LSB +: 2] == 2'd1 ? 7'h1f : FIFO_MIN_CELLS_M1));

    assign eim_high = {ext_to_int_ctrl_base[11:0], 9'h000};
    assign eim_low = 21'(eim_high + (21'(req.entry[10:0]) << EIM_ENTRY_SHIFT) + 21'(req.offset[1:0]));
    assign cb_high = {req.entry, 6'h00};
    assign cb_low = 21'(req.offset);
    assign rsm_high = {rx_reassembly_ctrl_base[2:0], req.entry[13:0], 4'h0};
    assign rsm_low = 21'(rsm_high[7:0] + req.offset[7:0]);
    assign txf_high = {tx_cell_fifo_base[11:0], 9'h000};
    assign txf_low = 21'(txf_high + (21'(txf_cell) << CELL_SHIFT) + 21'(req.offset[5:0]));
    assign rxf_high = {rx_cell_fifo_base[11:0], 9'h000};
    assign rxf_low = 21'(rxf_high + (21'(rxf_cell) << CELL_SHIFT) + 21'(req.offset[5:0]));

    // each address keeps the bits above its window untouched
    ema_merge u_eim (.high(eim_high), .low(eim_low), .mask(win8k), .addr(eim_addr));
    ema_merge u_cb (.high(cb_high), .low(cb_low), .mask(win_cbuf), .addr(cb_addr));
    ema_merge u_rsm (.high(rsm_high), .low(rsm_low), .mask(win_rsm), .addr(rsm_addr));
    ema_merge u_txf (.high(txf_high), .low(txf_low), .mask(win8k), .addr(txf_addr));
    ema_merge u_rxf (.high(rxf_high), .low(rxf_low), .mask(win8k), .addr(rxf_addr));

    ema_rsp_t next_rsp;
    logic next_rsp_valid;
    logic [7:0] req_cnt;

    always_comb begin
        next_rsp = rsp;
        next_rsp_valid = req_valid;
        next_status = status;
        if (req_valid) begin
            next_rsp.kind = req.kind;
            next_rsp.bad_code = 1'b0;
            next_rsp.mismatch = 1'b0;
            next_rsp.no_fifo = 1'b0;
            unique case (req.kind)
                K_EIM: next_rsp.addr = eim_addr;
                K_RXCB: begin
                    next_rsp.addr = cb_addr;
                    next_rsp.bad_code = req.eim_size > CBUF_CODE_MAX;
                    next_rsp.mismatch = req.eim_size != req.rsm_size;
                end
                K_RSM: next_rsp.addr = rsm_addr;
                K_TXF: begin
                    next_rsp.addr = txf_addr;
                    next_rsp.no_fifo = !txf_en;
                end
                K_RXF: begin
                    next_rsp.addr = rxf_addr;
                    next_rsp.no_fifo = !rxf_en;
                end
                default: begin
                    next_rsp.addr = 21'h00_0000;
                    next_rsp.bad_code = 1'b1;
                end
            endcase
            next_status = {8'(req_cnt + 8'h01), 5'h00, next_rsp.no_fifo, next_rsp.mismatch, next_rsp.bad_code};
        end
    end
    assign req_cnt = status[ST_CNT_LSB +: 8];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp <= '0;
            rsp_valid <= 1'b0;
            status <= RST_CFG;
        end else begin
            rsp <= next_rsp;
            rsp_valid <= next_rsp_valid;
            status <= next_status;
        end
    end

    default clocking cb_main @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_rsp_one_cycle: assert property (req_valid |=> rsp_valid)
        else $error("answer missing one cycle after request");
    a_no_stray_rsp: assert property (!req_valid |=> !rsp_valid)
        else $error("answer without request");
    a_eim_base_bits: assert property (req_valid && req.kind == K_EIM
        |=> rsp.addr[20:13] == $past(ext_to_int_ctrl_base[11:4]) && rsp.addr[1:0] == $past(req.offset[1:0]))
        else $error("eim address lost base bits");
    a_cbuf_high_bits: assert property (req_valid && req.kind == K_RXCB && req.eim_size == 3'h4
        |=> rsp.addr[20:10] == $past(req.entry[14:4]) && rsp.addr[9:0] == $past(req.offset))
        else $error("circular buffer address wrong for largest size");
    a_cbuf_size_agree: assert property (req_valid && req.kind == K_RXCB && req.eim_size != req.rsm_size
        |=> rsp.mismatch)
        else $error("size disagreement not flagged");
    a_rsm_base_bits: assert property (req_valid && req.kind == K_RSM
        |=> rsp.addr[20:18] == $past(rx_reassembly_ctrl_base[2:0]))
        else $error("reassembly base bits wrong");
    a_rsm_entry_bits: assert property (req_valid && req.kind == K_RSM && req.offset[7:0] == 8'h00
        |=> rsp.addr[17:0] == {$past(req.entry[13:0]), 4'h0})
        else $error("reassembly entry bits wrong");
    a_txf_base_bits: assert property (req_valid && req.kind == K_TXF
        |=> rsp.addr[20:13] == $past(tx_cell_fifo_base[11:4]))
        else $error("transmit fifo base bits wrong");
    a_rxf_base_bits: assert property (req_valid && req.kind == K_RXF
        |=> rsp.addr[20:13] == $past(rx_cell_fifo_base[11:4]))
        else $error("receive fifo base bits wrong");
    a_fifo_omitted: assert property (req_valid && req.kind == K_TXF && !txf_en |=> rsp.no_fifo)
        else $error("unallocated fifo not flagged");

    // slot, window and flag scope of formed addresses
    a_txf_slot_offset: assert property (req_valid && req.kind == K_TXF
        |=> rsp.addr[5:0] == $past(req.offset[5:0]))
        else $error("transmit cell slot offset wrong");
    a_rxf_slot_offset: assert property (req_valid && req.kind == K_RXF
        |=> rsp.addr[5:0] == $past(req.offset[5:0]))
        else $error("receive cell slot offset wrong");
    a_txf_full_index: assert property (req_valid && req.kind == K_TXF
        && cfg[CFG_TXF_SIZE_LSB +: 2] == 2'h3 && tx_cell_fifo_base[3:0] == 4'h0
        |=> rsp.addr[12:6] == $past(req.entry[6:0]))
        else $error("transmit cell index cut short");
    a_rxf_min_index: assert property (req_valid && req.kind == K_RXF
        && cfg[CFG_RXF_SIZE_LSB +: 2] == 2'h0 && rx_cell_fifo_base[3:0] == 4'h0
        |=> rsp.addr[12:10] == 3'h0)
        else $error("receive cell index beyond sixteen cells");
    a_rsm_low_bits: assert property (req_valid && req.kind == K_RSM
        |=> rsp.addr[3:0] == $past(req.offset[3:0]))
        else $error("reassembly low bits not from offset");
    a_rsm_window: assert property (req_valid && req.kind == K_RSM
        |=> rsp.addr[17:8] == $past(req.entry[13:4]))
        else $error("reassembly access left its 256-byte window");
    a_cbuf_min_size: assert property (req_valid && req.kind == K_RXCB && req.eim_size == 3'h0
        |=> rsp.addr[20:6] == $past(req.entry) && rsp.addr[5:0] == $past(req.offset[5:0]))
        else $error("circular buffer address wrong for smallest size");
    a_cbuf_top_bits: assert property (req_valid && req.kind == K_RXCB && req.eim_size <= CBUF_CODE_MAX
        |=> rsp.addr[20:10] == $past(req.entry[14:4]))
        else $error("offset carried into buffer entry bits");
    a_rsp_kind_echo: assert property (req_valid
        |=> rsp.kind == $past(req.kind))
        else $error("answer kind differs from request");
    a_cbuf_bad_code: assert property (req_valid && req.kind == K_RXCB && req.eim_size > CBUF_CODE_MAX
        |=> rsp.bad_code)
        else $error("illegal buffer size code not flagged");
    a_rsp_hold: assert property (!req_valid
        |=> $stable(rsp))
        else $error("answer changed without request");
    a_rxf_omitted: assert property (req_valid && req.kind == K_RXF && !rxf_en
        |=> rsp.no_fifo)
        else $error("unallocated receive fifo not flagged");
    a_txf_present: assert property (req_valid && req.kind == K_TXF && txf_en
        |=> !rsp.no_fifo)
        else $error("allocated transmit fifo flagged missing");
    a_rxf_present: assert property (req_valid && req.kind == K_RXF && rxf_en
        |=> !rsp.no_fifo)
        else $error("allocated receive fifo flagged missing");
    a_cbuf_size_same: assert property (req_valid && req.kind == K_RXCB && req.eim_size == req.rsm_size
        |=> !rsp.mismatch)
        else $error("agreeing sizes flagged as mismatch");
    a_mismatch_scope: assert property (req_valid && req.kind != K_RXCB
        |=> !rsp.mismatch)
        else $error("size mismatch flagged outside buffer access");
    a_nofifo_scope: assert property (req_valid && req.kind != K_TXF && req.kind != K_RXF
        |=> !rsp.no_fifo)
        else $error("missing fifo flagged outside fifo access");

    c_eim_req: cover property (req_valid && req.kind == K_EIM ##1 rsp_valid);
    c_cbuf_mismatch: cover property (rsp_valid && rsp.mismatch);
    c_cfg_write: cover property (state == S_WDATA && wr_idx == IDX_CFG);
    c_rxf_req: cover property (req_valid && req.kind == K_RXF && rxf_en);
    c_txf_full: cover property (req_valid && req.kind == K_TXF && cfg[CFG_TXF_SIZE_LSB +: 2] == 2'h3);
endmodule : ema_addr_gen

// ### rtl/ema_pkg.sv
// package: register map, field layout and carrier types for structure addressing
package ema_pkg;
    localparam int ADDR_W = 21;
    // printed offsets are word indices; byte address is four times the index
    localparam logic [29:0] IDX_TX_FIFO_BASE = 30'h0000_2050;
    localparam logic [29:0] IDX_RSM_BASE = 30'h0000_4000;
    localparam logic [29:0] IDX_RX_FIFO_BASE = 30'h0000_4020;
    localparam logic [29:0] IDX_EIM_BASE = 30'h0000_6042;
    localparam logic [29:0] IDX_CFG = 30'h0000_6046;
    localparam logic [29:0] IDX_STATUS = 30'h0000_6047;
    localparam logic [15:0] RST_BASE = 16'h0000;
    localparam logic [15:0] RST_CFG = 16'h0000;
    // cfg fields
    localparam int CFG_TXF_SIZE_LSB = 0;
    localparam int CFG_TXF_EN_BIT = 2;
    localparam int CFG_RXF_SIZE_LSB = 3;
    localparam int CFG_RXF_EN_BIT = 5;
    // status fields
    localparam int ST_BAD_CODE_BIT = 0;
    localparam int ST_MISMATCH_BIT = 1;
    localparam int ST_NO_FIFO_BIT = 2;
    localparam int ST_CNT_LSB = 8;
    // address geometry
    localparam int BASE_SHIFT = 9;
    localparam int WIN8K_W = 13;
    localparam int RSM_WIN_W = 8;
    localparam int RSM_SHIFT = 4;
    localparam int CBUF_MIN_SHIFT = 6;
    localparam int CELL_SHIFT = 6;
    localparam int EIM_ENTRY_SHIFT = 2;
    localparam logic [2:0] CBUF_CODE_MAX = 3'h4;
    localparam logic [6:0] FIFO_MIN_CELLS_M1 = 7'h0f;

    typedef enum logic [4:0] {
        K_EIM = 5'b0_0001,
        K_RXCB = 5'b0_0010,
        K_RSM = 5'b0_0100,
        K_TXF = 5'b0_1000,
        K_RXF = 5'b1_0000
    } ema_kind_t;

    typedef struct packed {
        ema_kind_t kind;
        logic [14:0] entry;
        logic [2:0] eim_size;
        logic [2:0] rsm_size;
        logic [9:0] offset;
    } ema_req_t;

    typedef struct packed {
        ema_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic bad_code;
        logic mismatch;
        logic no_fifo;
    } ema_rsp_t;
endpackage : ema_pkg

// ### rtl/ema_merge.sv
// module: joins fixed high address bits with a windowed low part
`timescale 1ns/1ps
module ema_merge (
    input wire logic [20:0] high, // base-supplied bits
    input wire logic [20:0] low, // entry and offset part
    input wire logic [20:0] mask, // ones where low wins
    output logic [20:0] addr // merged address
);
    // no carry can reach the base bits
    assign addr = (high & ~mask) | (low & mask);
endmodule : ema_merge

// ### verification/ema_mem_model.sv
// partner: external synchronous memory that logs each formed structure address
`timescale 1ns/1ps
module ema_mem_model (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, low
    input wire logic rsp_valid, // access strobe
    input wire ema_pkg::ema_rsp_t rsp, // formed address
    output logic [20:0] last_addr, // latest access
    output logic [7:0] n_access // accesses seen
);
    import ema_pkg::*;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_addr <= '0;
            n_access <= '0;
        end else if (rsp_valid) begin
            last_addr <= rsp.addr;
            n_access <= n_access + 8'h01;
        end
    end
endmodule : ema_mem_model

// ### verification/test_ext_memory_structure_addressing.sv
// bench: register access and structure address forming
`timescale 1ns/1ps
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ext_memory_structure_addressing;
    import ema_pkg::*;
    typedef struct packed {ema_req_t rq; logic [20:0] addr; logic [2:0] flg;} ema_row_t;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, req_valid, rsp_valid;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    ema_req_t req;
    ema_rsp_t rsp;
    logic [20:0] seen_addr;
    logic [7:0] seen_cnt;
    int miscompares, n_tests, cycles;
    ema_row_t rows [13];
    logic [29:0] regs [5];
    assign hready = hreadyout;
    ema_addr_gen i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
    ema_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .rsp_valid(rsp_valid), .rsp(rsp),
        .last_addr(seen_addr), .n_access(seen_cnt));
    task finish_test;
        $display("comparisons=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task bus(input logic [29:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        `CHECK(hresp, 1'b0)
    endtask : bus
    task rchk(input logic [29:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0000_0000);
        `CHECK(rd, exp)
    endtask : rchk
    task one(input ema_req_t r);
        @(posedge hclk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge hclk);
        req_valid <= 1'b0;
        #1;
        `CHECK(rsp_valid, 1'b1)
    endtask : one
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, req_valid, htrans, haddr, hwdata, req} = '0;
        hsize = 3'h2;
        {miscompares, n_tests, cycles} = '0;
        regs = '{IDX_TX_FIFO_BASE, IDX_RSM_BASE, IDX_RX_FIFO_BASE, IDX_EIM_BASE, IDX_CFG};
        rows[0] = '{'{K_EIM, 15'h0001, 3'h0, 3'h0, 10'h000}, 21'h1_4204, 3'b000};
        rows[1] = '{'{K_EIM, 15'h07ff, 3'h0, 3'h0, 10'h003}, 21'h1_41ff, 3'b000};
        rows[2] = '{'{K_RXCB, 15'h5555, 3'h0, 3'h0, 10'h2aa}, 21'h15_556a, 3'b000};
        rows[3] = '{'{K_RXCB, 15'h5555, 3'h1, 3'h1, 10'h2aa}, 21'h15_552a, 3'b000};
        rows[4] = '{'{K_RXCB, 15'h5555, 3'h2, 3'h2, 10'h2aa}, 21'h15_55aa, 3'b000};
        rows[5] = '{'{K_RXCB, 15'h5555, 3'h3, 3'h3, 10'h2aa}, 21'h15_54aa, 3'b000};
        rows[6] = '{'{K_RXCB, 15'h5555, 3'h4, 3'h4, 10'h2aa}, 21'h15_56aa, 3'b000};
        rows[7] = '{'{K_RXCB, 15'h5555, 3'h2, 3'h3, 10'h2aa}, 21'h15_55aa, 3'b010};
        rows[8] = '{'{K_RSM, 15'h1234, 3'h0, 3'h0, 10'h000}, 21'h15_2340, 3'b000};
        rows[9] = '{'{K_RSM, 15'h1234, 3'h0, 3'h0, 10'h0e5}, 21'h15_2325, 3'b000};
        rows[10] = '{'{K_TXF, 15'h000f, 3'h0, 3'h0, 10'h03f}, 21'h0_83ff, 3'b000};
        rows[11] = '{'{K_RXF, 15'h007f, 3'h0, 3'h0, 10'h005}, 21'h1_9fc5, 3'b000};
        rows[12] = '{'{K_RXF, 15'h0000, 3'h0, 3'h0, 10'h000}, 21'h1_8000, 3'b000};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (regs[i]) rchk(regs[i], {16'h0000, RST_BASE});
        bus(IDX_EIM_BASE, 1'b1, 32'hffff_80a1);
        bus(IDX_RSM_BASE, 1'b1, 32'h0000_0005);
        bus(IDX_TX_FIFO_BASE, 1'b1, 32'h0000_0040);
        bus(IDX_RX_FIFO_BASE, 1'b1, 32'h0000_00c0);
        bus(IDX_CFG, 1'b1, 32'h0000_003c);
        rchk(IDX_EIM_BASE, 32'h0000_80a1);
        bus(30'h0000_1000, 1'b1, 32'h0000_ffff);
        rchk(30'h0000_1000, 32'h0000_0000);
        bus(IDX_STATUS, 1'b1, 32'h0000_ffff);
        rchk(IDX_STATUS, 32'h0000_0000);
        for (int i = 0; i <= 13; i++) begin
            @(posedge hclk);
            req_valid <= (i < 13);
            if (i < 13) req <= rows[i].rq;
            #1;
            if (i > 0) begin
                `CHECK(rsp_valid, 1'b1)
                `CHECK(rsp.kind, rows[i-1].rq.kind)
                `CHECK(rsp.addr, rows[i-1].addr)
                `CHECK({rsp.bad_code, rsp.mismatch, rsp.no_fifo}, rows[i-1].flg)
            end
        end
        one('{K_RXCB, 15'h5555, 3'h5, 3'h5, 10'h2aa});
        `CHECK(rsp.bad_code, 1'b1)
        rchk(IDX_STATUS, 32'h0000_0e01);
        bus(IDX_CFG, 1'b1, 32'h0000_0038);
        one('{K_TXF, 15'h000f, 3'h0, 3'h0, 10'h03f});
        `CHECK(rsp.no_fifo, 1'b1)
        `CHECK(rsp.addr, 21'h0_83ff)
        rchk(IDX_STATUS, 32'h0000_0f04);
        `CHECK(seen_addr, 21'h0_83ff)
        `CHECK(seen_cnt, 8'h0f)
        // larger and smaller fifo size codes, last index of each cell range
        bus(IDX_CFG, 1'b1, 32'h0000_0027);
        one('{K_TXF, 15'h007f, 3'h0, 3'h0, 10'h000});
        `CHECK(rsp.addr, 21'h0_9fc0)
        `CHECK(rsp.no_fifo, 1'b0)
        one('{K_RXF, 15'h007f, 3'h0, 3'h0, 10'h000});
        `CHECK(rsp.addr, 21'h1_83c0)
        bus(IDX_CFG, 1'b1, 32'h0000_000e);
        one('{K_TXF, 15'h007f, 3'h0, 3'h0, 10'h000});
        `CHECK(rsp.addr, 21'h0_8fc0)
        one('{K_RXF, 15'h007f, 3'h0, 3'h0, 10'h000});
        `CHECK(rsp.addr, 21'h1_87c0)
        `CHECK(rsp.no_fifo, 1'b1)
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        `CHECK(rsp, '0)
        `CHECK(rsp_valid, 1'b0)
        @(posedge hclk);
        hresetn <= 1'b1;
        rchk(IDX_EIM_BASE, 32'h0000_0000);
        rchk(IDX_CFG, {16'h0000, RST_CFG});
        finish_test();
    end
endmodule : test_ext_memory_structure_addressing
